// ### rtpae_pkg.sv
// Purpose: Shared constants and types for the ROM timing and PCI address extension bank.
// Assumes: Byte addresses on a 12-bit host register port.
// Notes: Field positions are the low bit of each field.
`default_nettype none
package rtpae_pkg;
  // Register byte addresses.
  localparam logic [11:0] CTRL_OFS = 12'h013C;
  localparam logic [11:0] EXT_OFS = 12'h0140;
  localparam logic [11:0] DAC_LO_OFS = 12'h0200;
  localparam logic [11:0] DAC_HI_OFS = 12'h0204;
  localparam logic [11:0] ALIAS_OFS = 12'h020C;
  // Control register field positions.
  localparam int LSZ_POS = 10;
  localparam int WDE_POS = 13;
  localparam int RWID_POS = 14;
  localparam int ACC_POS = 16;
  localparam int BST_POS = 20;
  localparam int TRI_POS = 24;
  localparam int XCS_POS = 28;
  localparam int CFN_POS = 31;
  // Extension register field positions.
  localparam int EXT_MEM_POS = 15;
  localparam int EXT_IO_POS = 16;
  // Reset values.
  localparam logic [3:0] TIME_RST = 4'h0;
  localparam logic [2:0] XCS_RST = 3'h0;
  localparam logic [2:0] LSZ_RST = 3'h0;
  // ROM width strap codes.
  localparam logic [1:0] RW_BYTE = 2'h3;
  localparam logic [1:0] RW_WORD = 2'h1;
  localparam logic [1:0] RW_DWORD = 2'h2;
  // A programmed zero in a timing field stands for this many cycles.
  localparam logic [4:0] TIME_ZERO_CYC = 5'h10;
  // Narrowest queue count field is eight bits wide.
  localparam int LSZ_BASE_BITS = 8;

  typedef enum logic [1:0] {S_IDLE, S_FIRST, S_BURST, S_TRI} rtpae_st_t;

  // Host register request carried as one bundle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rtpae_bus_t;

  // Effective wait in cycles of a four-bit timing field.
  function automatic logic [4:0] eff_cycles(input logic [3:0] v);
    eff_cycles = (v == 4'h0) ? TIME_ZERO_CYC : {1'b0, v};
  endfunction
endpackage
`default_nettype wire

// ### rtpae_regs.sv
// Purpose: Core control upper fields, ROM read sequencer and PCI address extension.
// Assumes: All inputs synchronous to clk; host strobes are single cycle.
// Notes: Overview of operation in the list below.
// Overview of operation
// [RULE1] Watchdog enable: write one sets, reset clears.
// [RULE2] Watchdog set: timer four zero resets host.
// [RULE3] ROM width is strapped, read-only code.
// [RULE4] ROM width sets accesses packed per word.
// [RULE5] Access time waits before first data latch.
// [RULE6] Access and burst zero mean sixteen cycles.
// [RULE7] Burst time waits before later data latches.
// [RULE8] Tristate time holds bus after output enable.
// [RULE9] Tristate zero means sixteen; one is illegal.
// [RULE10] Each direction bit drives one chip-select.
// [RULE11] Software avoids outputs when arbiter is selected.
// [RULE12] Top control bit reads central-function pin.
// [RULE13] List size code selects queue depth.
// [RULE14] List size picks counting pointer bits.
// [RULE15] Extension bit fifteen drives memory address 31.
// [RULE16] Extension write loads bit fifteen.
// [RULE17] Offset 200h write clears, 204h sets.
// [RULE18] Alias location reads the memory address bit.
// [RULE19] Extension high half drives I/O address.
// [RULE20] Extension low bits read zero.
// [RULE21] Control fields clear on chip reset.
`timescale 1ns/1ps
`default_nettype none
module rtpae_regs #(
  parameter int ROM_AW = 24 // ROM address width.
) (
  input wire logic clk, // Core clock, 100 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire rtpae_pkg::rtpae_bus_t bus, // Host register request.
  output logic [31:0] rdata, // Read data, cycle after read strobe.
  input wire logic cfn_pin, // Central-function strap pin.
  input wire logic [1:0] rom_width_strap_lines, // ROM width strap.
  input wire logic t4_en, // Fourth timer enabled.
  input wire logic t4_zero, // Fourth timer count is zero.
  output logic host_rst, // Host processor reset request.
  output logic [2:0] xcs_oe, // Chip-select output enables.
  output logic [14:0] list_mask, // Counting bits [16:2] of queue pointers.
  input wire logic rom_req, // Start a 32-bit ROM read.
  input wire logic [ROM_AW-1:0] rom_base, // ROM byte address of the word.
  input wire logic [31:0] rom_din, // ROM data, narrow data in low bits.
  output logic [ROM_AW-1:0] rom_addr, // ROM address.
  output logic rom_ce_n, // ROM chip enable, active low.
  output logic rom_oe_n, // ROM output enable, active low.
  output logic [31:0] rom_word, // Packed ROM read result.
  output logic rom_done, // Result valid, one-cycle pulse.
  output logic bus_free, // Other agents may drive the data bus.
  input wire logic pci_req, // Host-originated PCI access.
  input wire logic pci_io, // High for I/O space, low for memory.
  input wire logic [31:0] host_addr, // Host address of the access.
  output logic [31:0] pci_addr // Address driven onto PCI.
);

  // The sequencer and pins need at least byte steps within a real address.
  if (ROM_AW < 2 || ROM_AW > 32) begin : g_aw_chk
    $error("ROM_AW must lie between 2 and 32");
  end

  typedef struct packed {
    logic strap_done;
    logic [1:0] rwid;
    logic wde;
    logic [3:0] acc;
    logic [3:0] bst;
    logic [3:0] tri_t;
    logic [2:0] xcs;
    logic [2:0] lsz;
    logic ext_mem;
    logic [15:0] ext_io;
    logic [31:0] rdata;
    logic host_rst;
    logic [14:0] mask;
    rtpae_pkg::rtpae_st_t st;
    logic [4:0] cnt;
    logic [1:0] beat;
    logic [ROM_AW-1:0] addr;
    logic [31:0] data;
    logic ce_n;
    logic oe_n;
    logic done;
    logic free;
    logic [31:0] pci_addr;
  } rtpae_state_t;

  rtpae_state_t s_q;
  rtpae_state_t s_d;

  logic [31:0] ctrl_rd;
  logic [31:0] ext_rd;
  logic [1:0] last_beat;
  logic [31:0] packed_w;

  // Read views of the two registers.
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[rtpae_pkg::LSZ_POS +: 3] = s_q.lsz;
    ctrl_rd[rtpae_pkg::WDE_POS] = s_q.wde;
    ctrl_rd[rtpae_pkg::RWID_POS +: 2] = s_q.rwid;
    ctrl_rd[rtpae_pkg::ACC_POS +: 4] = s_q.acc;
    ctrl_rd[rtpae_pkg::BST_POS +: 4] = s_q.bst;
    ctrl_rd[rtpae_pkg::TRI_POS +: 4] = s_q.tri_t;
    ctrl_rd[rtpae_pkg::XCS_POS +: 3] = s_q.xcs;
    // [RULE12] Live strap level.
    ctrl_rd[rtpae_pkg::CFN_POS] = cfn_pin;
    // [RULE20] Low bits stay zero.
    ext_rd = 32'h0000_0000;
    ext_rd[rtpae_pkg::EXT_MEM_POS] = s_q.ext_mem;
    ext_rd[rtpae_pkg::EXT_IO_POS +: 16] = s_q.ext_io;
  end

  // Beats per word and the packed word including the beat being latched.
  // An undefined width code is served as a full-width ROM.
  always_comb begin
    packed_w = s_q.data;
    // [RULE4] Width sets beats.
    unique case (s_q.rwid)
      rtpae_pkg::RW_BYTE: begin
        last_beat = 2'h3;
        packed_w[{s_q.beat, 3'h0} +: 8] = rom_din[7:0];
      end
      rtpae_pkg::RW_WORD: begin
        last_beat = 2'h1;
        packed_w[{s_q.beat[0], 4'h0} +: 16] = rom_din[15:0];
      end
      default: begin
        last_beat = 2'h0;
        packed_w = rom_din;
      end
    endcase
  end

  // Next-state logic for registers, ROM sequencer and address extension.
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.done = 1'b0;
    // Strap sampled on the first edge after reset release.
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      // [RULE3] Strap latched once.
      s_d.rwid = rom_width_strap_lines;
    end
    // Host writes.
    if (bus.wr) begin
      unique case (bus.addr)
        rtpae_pkg::CTRL_OFS: begin
          s_d.lsz = bus.wdata[rtpae_pkg::LSZ_POS +: 3];
          // [RULE1] Write one sets only.
          s_d.wde = s_q.wde | bus.wdata[rtpae_pkg::WDE_POS];
          s_d.acc = bus.wdata[rtpae_pkg::ACC_POS +: 4];
          s_d.bst = bus.wdata[rtpae_pkg::BST_POS +: 4];
          s_d.tri_t = bus.wdata[rtpae_pkg::TRI_POS +: 4];
          // [RULE10] Direction bits stored.
          s_d.xcs = bus.wdata[rtpae_pkg::XCS_POS +: 3];
        end
        rtpae_pkg::EXT_OFS: begin
          // [RULE16] Load memory address bit.
          s_d.ext_mem = bus.wdata[rtpae_pkg::EXT_MEM_POS];
          s_d.ext_io = bus.wdata[rtpae_pkg::EXT_IO_POS +: 16];
        end
        // [RULE17] Side effects of the two address registers.
        rtpae_pkg::DAC_LO_OFS: s_d.ext_mem = 1'b0;
        rtpae_pkg::DAC_HI_OFS: s_d.ext_mem = 1'b1;
        default: s_d.ext_mem = s_q.ext_mem;
      endcase
    end
    // Host reads; unmapped addresses answer zero.
    if (bus.rd) begin
      unique case (bus.addr)
        rtpae_pkg::CTRL_OFS: s_d.rdata = ctrl_rd;
        rtpae_pkg::EXT_OFS: s_d.rdata = ext_rd;
        // [RULE18] Alias read of the bit.
        rtpae_pkg::ALIAS_OFS: s_d.rdata = {16'h0000, s_q.ext_mem, 15'h0000};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // [RULE2] Watchdog reset of the host.
    s_d.host_rst = s_q.wde & t4_en & t4_zero;
    // [RULE13] Count field grows by one bit per code step.
    // [RULE14] Mask picks the counting pointer bits.
    for (int i = 0; i < 15; i++) begin
      s_d.mask[i] = (i < rtpae_pkg::LSZ_BASE_BITS + int'(s_q.lsz));
    end
    // [RULE15] Memory space takes bit 31 from the extension.
    // [RULE19] I/O space takes the high half from the extension.
    if (pci_req) begin
      s_d.pci_addr = pci_io ? {s_q.ext_io, host_addr[15:0]}
                            : {s_q.ext_mem, host_addr[30:0]};
    end
    // ROM read sequencer. Requests while busy are ignored.
    unique case (s_q.st)
      rtpae_pkg::S_IDLE: begin
        if (rom_req && s_q.strap_done) begin
          s_d.st = rtpae_pkg::S_FIRST;
          s_d.addr = rom_base;
          s_d.ce_n = 1'b0;
          s_d.oe_n = 1'b0;
          s_d.free = 1'b0;
          s_d.beat = 2'h0;
          s_d.data = 32'h0000_0000;
          // [RULE5] First access wait.
          // [RULE6] Zero stands for sixteen.
          s_d.cnt = rtpae_pkg::eff_cycles(s_q.acc);
        end
      end
      rtpae_pkg::S_FIRST, rtpae_pkg::S_BURST: begin
        if (s_q.cnt == 5'h01) begin
          s_d.data = packed_w;
          if (s_q.beat == last_beat) begin
            s_d.st = rtpae_pkg::S_TRI;
            s_d.ce_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.done = 1'b1;
            // [RULE8] Tristate hold.
            // [RULE9] Zero stands for sixteen.
            s_d.cnt = rtpae_pkg::eff_cycles(s_q.tri_t);
          end else begin
            s_d.st = rtpae_pkg::S_BURST;
            s_d.beat = s_q.beat + 2'h1;
            // Byte ROMs step by one, word ROMs by two.
            s_d.addr = s_q.addr + ((s_q.rwid == rtpae_pkg::RW_BYTE) ? ROM_AW'(1) : ROM_AW'(2));
            // [RULE7] Later access wait.
            s_d.cnt = rtpae_pkg::eff_cycles(s_q.bst);
          end
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      rtpae_pkg::S_TRI: begin
        if (s_q.cnt == 5'h01) begin
          s_d.st = rtpae_pkg::S_IDLE;
          s_d.free = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
    endcase
  end

  // State register; extension fields are unspecified, cleared here for determinism.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // [RULE21] Control fields clear.
      s_q <= '0;
      s_q.acc <= rtpae_pkg::TIME_RST;
      s_q.bst <= rtpae_pkg::TIME_RST;
      s_q.tri_t <= rtpae_pkg::TIME_RST;
      s_q.xcs <= rtpae_pkg::XCS_RST;
      s_q.lsz <= rtpae_pkg::LSZ_RST;
      s_q.st <= rtpae_pkg::S_IDLE;
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.free <= 1'b1;
      s_q.mask <= 15'h00FF;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign rdata = s_q.rdata;
  assign host_rst = s_q.host_rst;
  assign xcs_oe = s_q.xcs;
  assign list_mask = s_q.mask;
  assign rom_addr = s_q.addr;
  assign rom_ce_n = s_q.ce_n;
  assign rom_oe_n = s_q.oe_n;
  assign rom_word = s_q.data;
  assign rom_done = s_q.done;
  assign bus_free = s_q.free;
  assign pci_addr = s_q.pci_addr;

  // Checks.
  chk_wde_sticky: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
    s_q.wde |=> s_q.wde) else $error("watchdog enable cleared");
  chk_wdog_reset: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
    s_q.wde && t4_en && t4_zero |=> host_rst) else $error("watchdog reset missing");
  chk_rwid_stable: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
    s_q.strap_done |=> $stable(s_q.rwid)) else $error("rom width changed");
  chk_acc_load: assert property (@(posedge clk) disable iff (!rstn) // [RULE5]
    $rose(s_q.st == rtpae_pkg::S_FIRST) |-> s_q.cnt == rtpae_pkg::eff_cycles(s_q.acc))
    else $error("access wait wrong");
  chk_acc_zero: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
    $rose(s_q.st == rtpae_pkg::S_FIRST) && s_q.acc == 4'h0 |-> s_q.cnt == 5'h10)
    else $error("zero access not sixteen");
  chk_bst_load: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
    $changed(s_q.beat) && s_q.beat != 2'h0 |-> s_q.cnt == rtpae_pkg::eff_cycles(s_q.bst))
    else $error("burst wait wrong");
  chk_tri_hold: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
    $rose(s_q.st == rtpae_pkg::S_TRI) |-> !bus_free [*2]) else $error("bus freed early");
  chk_done_beats: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
    rom_done |-> (s_q.rwid == rtpae_pkg::RW_BYTE) == ($past(s_q.beat) == 2'h3))
    else $error("beat count wrong");
  chk_xcs_dir: assert property (@(posedge clk) disable iff (!rstn) // [RULE10]
    bus.wr && bus.addr == rtpae_pkg::CTRL_OFS |=> xcs_oe == $past(bus.wdata[30:28]))
    else $error("direction not applied");
  chk_cfn_read: assert property (@(posedge clk) disable iff (!rstn) // [RULE12]
    bus.rd && bus.addr == rtpae_pkg::CTRL_OFS |=> rdata[31] == $past(cfn_pin))
    else $error("strap read wrong");
  chk_mask_size: assert property (@(posedge clk) disable iff (!rstn) // [RULE13]
    ##1 $countones(list_mask) == 8 + $past(s_q.lsz)) else $error("list mask wrong");
  chk_mem_addr: assert property (@(posedge clk) disable iff (!rstn) // [RULE15]
    pci_req && !pci_io |=> pci_addr[31] == $past(s_q.ext_mem)) else $error("addr31 wrong");
  chk_io_addr: assert property (@(posedge clk) disable iff (!rstn) // [RULE19]
    pci_req && pci_io |=> pci_addr[31:16] == $past(s_q.ext_io)) else $error("io addr wrong");
  chk_ext_write: assert property (@(posedge clk) disable iff (!rstn) // [RULE16]
    bus.wr && bus.addr == rtpae_pkg::EXT_OFS |=> s_q.ext_mem == $past(bus.wdata[15]))
    else $error("ext bit not loaded");
  chk_dac_effect: assert property (@(posedge clk) disable iff (!rstn) // [RULE17]
    bus.wr && bus.addr == rtpae_pkg::DAC_HI_OFS |=> s_q.ext_mem) else $error("set missing");
  chk_alias_read: assert property (@(posedge clk) disable iff (!rstn) // [RULE18]
    bus.rd && bus.addr == rtpae_pkg::ALIAS_OFS |=> rdata[15] == s_q.ext_mem)
    else $error("alias read wrong");
  chk_ext_low: assert property (@(posedge clk) disable iff (!rstn) // [RULE20]
    bus.rd && bus.addr == rtpae_pkg::EXT_OFS |=> rdata[14:0] == 15'h0000)
    else $error("low bits not zero");

endmodule // rtpae_regs
`default_nettype wire

// ### rtpae_rom_model.sv
// Purpose: Behavioural ROM on the far side of the sequencer.
// Assumes: Data is a pattern derived from the low address byte.
// Notes: Data bits show the inverse of the last value once the ROM is deselected.
`timescale 1ns/1ps
`default_nettype none
module rtpae_rom_model #(
  parameter int AW = 24 // ROM address width.
) (
  input wire logic clk, // Core clock.
  input wire logic [AW-1:0] rom_addr, // ROM address.
  input wire logic rom_ce_n, // Chip enable, active low.
  input wire logic rom_oe_n, // Output enable, active low.
  output logic [31:0] rom_din // ROM data toward the device.
);
  logic [31:0] last_q = 32'h0000_0000;
  logic [7:0] a;
  // Deselected, the bus shows the inverse so stale data is never read as good.
  always_comb begin
    a = rom_addr[7:0];
    rom_din = (!rom_ce_n && !rom_oe_n) ? {a + 8'h03, a + 8'h02, a + 8'h01, a} : ~last_q;
  end
  // Remember the last driven value.
  always_ff @(posedge clk) begin
    if (!rom_ce_n && !rom_oe_n) begin
      last_q <= rom_din;
    end
  end
endmodule // rtpae_rom_model
`default_nettype wire

// ### rtpae_regs_bench.sv
// Purpose: Self-checking bench for the ROM timing and PCI address extension bank.
// Assumes: The ROM model answers with an address-derived pattern.
// Notes: Each strap setting is run after a reset of its own.
`timescale 1ns/1ps
`default_nettype none
module rtpae_regs_bench;
  logic clk, rstn, cfn_pin, t4_en, t4_zero, host_rst, rom_req, rom_ce_n, rom_oe_n;
  logic rom_done, bus_free, pci_req, pci_io;
  logic [1:0] rom_width_strap_lines;
  logic [2:0] xcs_oe;
  logic [14:0] list_mask;
  logic [23:0] rom_base, rom_addr;
  logic [31:0] rdata, rom_din, rom_word, host_addr, pci_addr, d;
  rtpae_pkg::rtpae_bus_t bus;
  int failures, check_count;
  logic [1:0] wid_t [3] = '{2'h3, 2'h1, 2'h2};
  logic [3:0] acc_t [3] = '{4'h3, 4'h0, 4'hF};
  logic [3:0] bst_t [3] = '{4'h4, 4'h0, 4'h3};
  logic [3:0] tri_t [3] = '{4'h5, 4'h0, 4'hF};
  logic [2:0] xcs_t [3] = '{3'h5, 3'h2, 3'h7};
  int beats_t [3] = '{4, 2, 1};

  rtpae_regs #(.ROM_AW(24)) dut (.clk, .rstn, .bus, .rdata, .cfn_pin, .rom_width_strap_lines,
    .t4_en, .t4_zero, .host_rst, .xcs_oe, .list_mask, .rom_req, .rom_base, .rom_din,
    .rom_addr, .rom_ce_n, .rom_oe_n, .rom_word, .rom_done, .bus_free, .pci_req, .pci_io,
    .host_addr, .pci_addr);
  rtpae_rom_model #(.AW(24)) rom (.clk, .rom_addr, .rom_ce_n, .rom_oe_n, .rom_din);

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each access starts at an edge so strobes never change twice in one step.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask

  task automatic pci(input logic io, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    pci_req <= 1'b1;
    pci_io <= io;
    host_addr <= a;
    @(posedge clk);
    pci_req <= 1'b0;
    #1;
    chk(pci_addr, exp);
  endtask

  function automatic int eff(input logic [3:0] v);
    return (v == 4'h0) ? 16 : int'(v);
  endfunction

  // Counts edges to completion, then to release of the shared data bus.
  task automatic rom_rd(input logic [7:0] b, input int exp_k, input int exp_t);
    int k;
    k = 0;
    @(posedge clk);
    rom_req <= 1'b1;
    rom_base <= {16'h0012, b};
    @(posedge clk);
    rom_req <= 1'b0;
    #1;
    // The first access must present the word address with both strobes low.
    chk({6'h00, rom_ce_n, rom_oe_n, rom_addr}, {8'h00, 16'h0012, b});
    while (rom_done !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(32'(k), 32'(exp_k));
    chk(rom_word, {b + 8'h03, b + 8'h02, b + 8'h01, b});
    chk({30'h0000_0000, rom_ce_n, rom_oe_n}, 32'h0000_0003);
    k = 0;
    while (bus_free !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(32'(k), 32'(exp_t));
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // A hang counts as a mismatch and ends the run the usual way.
  initial begin
    #400_000;
    failures++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    bus = '0;
    {cfn_pin, t4_en, t4_zero, rom_req, pci_req, pci_io} = 6'b011000;
    rom_width_strap_lines = 2'h3;
    rom_base = 24'h00_0000;
    host_addr = 32'h0000_0000;
    failures = 0;
    check_count = 0;
    // Only legal timing and direction values.
    for (int i = 0; i < 3; i++) begin
      rom_width_strap_lines <= wid_t[i];
      cfn_pin <= i[0];
      do_reset();
      // Reset readback of the control fields.
      rd(rtpae_pkg::CTRL_OFS, d);
      chk(d, {i[0], 15'h0000, wid_t[i], 14'h0000});
      chk({31'h0000_0000, host_rst}, 32'h0000_0000);
      wr(rtpae_pkg::CTRL_OFS, {1'b0, xcs_t[i], tri_t[i], bst_t[i], acc_t[i], 16'h0000});
      rd(rtpae_pkg::CTRL_OFS, d);
      chk(d, {i[0], xcs_t[i], tri_t[i], bst_t[i], acc_t[i], wid_t[i], 14'h0000});
      chk({29'h0000_0000, xcs_oe}, {29'h0000_0000, xcs_t[i]});
      rom_rd({4'(i + 3), 4'h0}, eff(acc_t[i]) + (beats_t[i] - 1) * eff(bst_t[i]), eff(tri_t[i]));
    end
    // Watchdog enable is sticky and gates the host reset.
    wr(rtpae_pkg::CTRL_OFS, 32'h0000_2000);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0000_0000, host_rst}, 32'h0000_0001);
    wr(rtpae_pkg::CTRL_OFS, 32'h0000_0000);
    rd(rtpae_pkg::CTRL_OFS, d);
    chk({31'h0000_0000, d[13]}, 32'h0000_0001);
    t4_zero <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0000_0000, host_rst}, 32'h0000_0000);
    for (int l = 0; l < 8; l++) begin
      wr(rtpae_pkg::CTRL_OFS, {19'h0_0000, 3'(l), 10'h000});
      repeat (2) @(posedge clk);
      #1;
      chk({17'h0_0000, list_mask}, 32'((1 << (8 + l)) - 1));
    end
    wr(rtpae_pkg::EXT_OFS, 32'hABCD_FFFF);
    rd(rtpae_pkg::EXT_OFS, d);
    chk(d, 32'hABCD_8000);
    pci(1'b0, 32'h1234_5678, 32'h9234_5678);
    pci(1'b1, 32'h0000_BEEF, 32'hABCD_BEEF);
    wr(rtpae_pkg::DAC_LO_OFS, 32'hFFFF_FFFF);
    rd(rtpae_pkg::ALIAS_OFS, d);
    chk(d, 32'h0000_0000);
    pci(1'b0, 32'h9234_5678, 32'h1234_5678);
    wr(rtpae_pkg::DAC_HI_OFS, 32'h0000_0000);
    rd(rtpae_pkg::ALIAS_OFS, d);
    chk(d, 32'h0000_8000);
    wr(rtpae_pkg::EXT_OFS, 32'h0000_7FFF);
    rd(rtpae_pkg::EXT_OFS, d);
    chk(d, 32'h0000_0000);
    // Unmapped places read zero and ignore writes.
    wr(12'hFF0, 32'hFFFF_FFFF);
    rd(12'hFF0, d);
    chk(d, 32'h0000_0000);
    // Only a chip reset clears the watchdog enable.
    do_reset();
    rd(rtpae_pkg::CTRL_OFS, d);
    chk({31'h0000_0000, d[13]}, 32'h0000_0000);
    finish_test();
  end
endmodule // rtpae_regs_bench
`default_nettype wire
